// >>> design/afp_pkg.sv
package afp_pkg;

    // =====================================================================
    // geometry
    localparam int          DATA_W      = 32;
    localparam int          FIFO_DEPTH  = 128;
    localparam int          PTR_W       = 7;
    localparam int          CNT_W       = 8;
    localparam int          NUM_CH      = 2;
    localparam int          CH_LEFT     = 0;
    localparam int          CH_RIGHT    = 1;

    // =====================================================================
    // register byte addresses
    localparam logic [31:0] ADDR_RIGHT  = 32'h1000303C;
    localparam logic [31:0] ADDR_CTRL   = 32'h10003040;
    localparam logic [31:0] ADDR_OCC    = 32'h10003044;
    localparam logic [31:0] ADDR_LEFT   = 32'h10003048;

    // =====================================================================
    // audio_control fields
    localparam int          CTRL_RX_IE    = 0;
    localparam int          CTRL_TX_IE    = 1;
    localparam int          CTRL_RX_FLUSH = 2;
    localparam int          CTRL_TX_FLUSH = 3;
    localparam int          CTRL_RX_PEND  = 8;
    localparam int          CTRL_TX_PEND  = 9;

    // =====================================================================
    // fifo_occupancy fields
    localparam int          OCC_IN_RIGHT  = 0;
    localparam int          OCC_IN_LEFT   = 8;
    localparam int          OCC_OUT_RIGHT = 16;
    localparam int          OCC_OUT_LEFT  = 24;

    // =====================================================================
    // thresholds: 75 % and 25 % of depth
    localparam logic [CNT_W-1:0] DEPTH_CNT = CNT_W'(FIFO_DEPTH);
    localparam logic [CNT_W-1:0] RX_THRESH = CNT_W'(FIFO_DEPTH * 3 / 4);
    localparam logic [CNT_W-1:0] TX_THRESH = CNT_W'(FIFO_DEPTH / 4);

    // =====================================================================
    // timing
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          SAMPLE_RATE_HZ   = 48000;
    localparam int          SAMPLE_PERIOD_NS = 1000000000 / SAMPLE_RATE_HZ;
    localparam int          SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int          PACE_W           = 12;

    // =====================================================================
    // bus encodings
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic        HRESP_OKAY    = 1'h0;

    typedef struct packed {
        logic [DATA_W-1:0] left;
        logic [DATA_W-1:0] right;
    } afp_stereo_s;

endpackage

// >>> design/afp_sample_fifo.sv
`timescale 1ns/10ps
module afp_sample_fifo (
    input  wire logic                       clk,      // system clock
    input  wire logic                       rst,      // sync reset
    input  wire logic                       flush,    // held clear while high
    input  wire logic                       push,     // write request
    input  wire logic [afp_pkg::DATA_W-1:0] pushData, // write word
    input  wire logic                       pop,      // read request
    output logic      [afp_pkg::DATA_W-1:0] head,     // oldest word
    output logic      [afp_pkg::CNT_W-1:0]  count,    // words stored
    output logic                            full,     // no room
    output logic                            empty     // nothing stored
);

    logic [afp_pkg::DATA_W-1:0] mem [afp_pkg::FIFO_DEPTH];
    logic [afp_pkg::PTR_W-1:0]  wrPtr;
    logic [afp_pkg::PTR_W-1:0]  rdPtr;
    logic                       doPush;
    logic                       doPop;

    assign full   = (count == afp_pkg::DEPTH_CNT);
    assign empty  = (count == '0);
    assign doPush = push && !full && !flush;
    assign doPop  = pop && !empty && !flush;
    assign head   = mem[rdPtr];

    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[wrPtr] <= pushData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || flush) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doPush) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doPop) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (doPush && !doPop) begin
                count <= count + 1'b1;
            end else if (doPop && !doPush) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule

// >>> design/afp_sample_pacer.sv
`timescale 1ns/10ps
module afp_sample_pacer (
    input  wire logic clk,  // system clock
    input  wire logic rst,  // sync reset
    output logic      tick  // one pulse per sample period
);

    localparam logic [afp_pkg::PACE_W-1:0] LAST =
        afp_pkg::PACE_W'(afp_pkg::SAMPLE_CYCLES - 1);

    logic [afp_pkg::PACE_W-1:0] cycleCount;

    always_ff @(posedge clk) begin
        if (rst) begin
            cycleCount <= '0;
            tick       <= 1'b0;
        end else if (cycleCount == LAST) begin
            cycleCount <= '0;
            tick       <= 1'b1;
        end else begin
            cycleCount <= cycleCount + 1'b1;
            tick       <= 1'b0;
        end
    end

endmodule

// >>> design/afp_audio_port.sv
`timescale 1ns/10ps
module afp_audio_port (
    input  wire logic                 core_clk,   // system clock
    input  wire logic                 rst,        // sync reset, active high
    input  wire logic                 hsel,       // slave select
    input  wire logic [31:0]          haddr,      // byte address
    input  wire logic [1:0]           htrans,     // transfer type
    input  wire logic                 hwrite,     // write when high
    input  wire logic [2:0]           hsize,      // word only
    input  wire logic [31:0]          hwdata,     // write data
    input  wire logic                 hready,     // bus ready
    output logic                      hreadyout,  // always ready
    output logic                      hresp,      // always okay
    output logic      [31:0]          hrdata,     // read data
    input  wire afp_pkg::afp_stereo_s captureIn,  // codec capture pair
    output afp_pkg::afp_stereo_s      playOut,    // codec playback pair
    output logic                      sampleTick, // sample period strobe
    output logic                      irq         // interrupt request
);

    // =====================================================================
    // declarations
    localparam int NCH = afp_pkg::NUM_CH;

    logic                        rxIrqEnable;
    logic                        txIrqEnable;
    logic                        rxFifoFlush;
    logic                        txFifoFlush;
    logic                        rxIrqPending;
    logic                        txIrqPending;

    logic [NCH-1:0]              inPush;
    logic [NCH-1:0]              inPop;
    logic [NCH-1:0]              inFull;
    logic [NCH-1:0]              inEmpty;
    logic [afp_pkg::DATA_W-1:0]  inHead    [NCH];
    logic [afp_pkg::CNT_W-1:0]   inCount   [NCH];
    logic [afp_pkg::DATA_W-1:0]  capWord   [NCH];

    logic [NCH-1:0]              outPush;
    logic [NCH-1:0]              outPop;
    logic [NCH-1:0]              outFull;
    logic [NCH-1:0]              outEmpty;
    logic [afp_pkg::DATA_W-1:0]  outHead   [NCH];
    logic [afp_pkg::CNT_W-1:0]   outCount  [NCH];
    logic [afp_pkg::CNT_W-1:0]   outSpace  [NCH];
    logic [afp_pkg::DATA_W-1:0]  playWord  [NCH];

    logic [NCH-1:0]              inHigh;
    logic [NCH-1:0]              outLow;
    logic [NCH-1:0]              outAbove;

    logic                        addrPhase;
    logic                        rdAccess;
    logic [NCH-1:0]              addrIsData;
    logic                        wrPending;
    logic [31:0]                 wrAddr;
    logic [31:0]                 ctrlWord;
    logic [31:0]                 occWord;
    logic [31:0]                 next_hrdata;

    // =====================================================================
    // sample pacing
    afp_sample_pacer pacer (
        .clk  (core_clk),
        .rst  (rst),
        .tick (sampleTick)
    );

    assign capWord[afp_pkg::CH_LEFT]  = captureIn.left;
    assign capWord[afp_pkg::CH_RIGHT] = captureIn.right;

    // =====================================================================
    // bus address phase
    assign hreadyout = 1'b1;
    assign hresp     = afp_pkg::HRESP_OKAY;
    assign addrPhase = hsel && hready && (htrans == afp_pkg::HTRANS_NONSEQ);
    assign rdAccess  = addrPhase && !hwrite;

    assign addrIsData[afp_pkg::CH_LEFT]  = (haddr == afp_pkg::ADDR_LEFT);
    assign addrIsData[afp_pkg::CH_RIGHT] = (haddr == afp_pkg::ADDR_RIGHT);

    // =====================================================================
    // per-channel FIFOs and their movers
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_chan
            localparam logic [31:0] CH_ADDR = (ch == afp_pkg::CH_LEFT) ?
                afp_pkg::ADDR_LEFT : afp_pkg::ADDR_RIGHT;

            // capture side: codec push, bus pop
            assign inPush[ch] = sampleTick && !inFull[ch];
            assign inPop[ch]  = rdAccess && addrIsData[ch] && !inEmpty[ch];

            afp_sample_fifo inFifo (
                .clk      (core_clk),
                .rst      (rst),
                .flush    (rxFifoFlush),
                .push     (inPush[ch]),
                .pushData (capWord[ch]),
                .pop      (inPop[ch]),
                .head     (inHead[ch]),
                .count    (inCount[ch]),
                .full     (inFull[ch]),
                .empty    (inEmpty[ch])
            );

            // playback side: bus push, codec pop
            assign outPush[ch] = wrPending && (wrAddr == CH_ADDR) && !outFull[ch];
            assign outPop[ch]  = sampleTick && !outEmpty[ch];

            afp_sample_fifo outFifo (
                .clk      (core_clk),
                .rst      (rst),
                .flush    (txFifoFlush),
                .push     (outPush[ch]),
                .pushData (hwdata),
                .pop      (outPop[ch]),
                .head     (outHead[ch]),
                .count    (outCount[ch]),
                .full     (outFull[ch]),
                .empty    (outEmpty[ch])
            );

            assign outSpace[ch] = afp_pkg::DEPTH_CNT - outCount[ch];
            assign inHigh[ch]   = (inCount[ch] >= afp_pkg::RX_THRESH);
            assign outLow[ch]   = (outCount[ch] < afp_pkg::TX_THRESH);
            assign outAbove[ch] = (outCount[ch] > afp_pkg::TX_THRESH);

            // playback word stays until the next sample period with data
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    playWord[ch] <= '0;
                end else if (outPop[ch]) begin
                    playWord[ch] <= outHead[ch];
                end
            end
        end
    endgenerate

    assign playOut.left  = playWord[afp_pkg::CH_LEFT];
    assign playOut.right = playWord[afp_pkg::CH_RIGHT];

    // =====================================================================
    // write data phase
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wrPending <= 1'b0;
            wrAddr    <= '0;
        end else begin
            wrPending <= addrPhase && hwrite;
            if (addrPhase && hwrite) begin
                wrAddr <= haddr;
            end
        end
    end

    // =====================================================================
    // control register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rxIrqEnable <= 1'b0;
            txIrqEnable <= 1'b0;
            rxFifoFlush <= 1'b0;
            txFifoFlush <= 1'b0;
        end else if (wrPending && (wrAddr == afp_pkg::ADDR_CTRL)) begin
            rxIrqEnable <= hwdata[afp_pkg::CTRL_RX_IE];
            txIrqEnable <= hwdata[afp_pkg::CTRL_TX_IE];
            rxFifoFlush <= hwdata[afp_pkg::CTRL_RX_FLUSH];
            txFifoFlush <= hwdata[afp_pkg::CTRL_TX_FLUSH];
        end
    end

    // =====================================================================
    // pending flags and request
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rxIrqPending <= 1'b0;
        end else if (rxIrqEnable && (|inHigh)) begin
            rxIrqPending <= 1'b1;
        end else begin
            rxIrqPending <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            txIrqPending <= 1'b0;
        end else if (txIrqEnable && (|outLow)) begin
            txIrqPending <= 1'b1;
        end else if (!txIrqEnable || (&outAbove)) begin
            txIrqPending <= 1'b0;
        end
    end

    assign irq = rxIrqPending || txIrqPending;

    // =====================================================================
    // read views
    always_comb begin
        ctrlWord                         = '0;
        ctrlWord[afp_pkg::CTRL_RX_IE]    = rxIrqEnable;
        ctrlWord[afp_pkg::CTRL_TX_IE]    = txIrqEnable;
        ctrlWord[afp_pkg::CTRL_RX_FLUSH] = rxFifoFlush;
        ctrlWord[afp_pkg::CTRL_TX_FLUSH] = txFifoFlush;
        ctrlWord[afp_pkg::CTRL_RX_PEND]  = rxIrqPending;
        ctrlWord[afp_pkg::CTRL_TX_PEND]  = txIrqPending;
    end

    always_comb begin
        occWord = '0;
        occWord[afp_pkg::OCC_IN_RIGHT +: afp_pkg::CNT_W] =
            inCount[afp_pkg::CH_RIGHT];
        occWord[afp_pkg::OCC_IN_LEFT +: afp_pkg::CNT_W] =
            inCount[afp_pkg::CH_LEFT];
        occWord[afp_pkg::OCC_OUT_RIGHT +: afp_pkg::CNT_W] =
            outSpace[afp_pkg::CH_RIGHT];
        occWord[afp_pkg::OCC_OUT_LEFT +: afp_pkg::CNT_W] =
            outSpace[afp_pkg::CH_LEFT];
    end

    always_comb begin
        next_hrdata = '0;
        if (addrIsData[afp_pkg::CH_LEFT] && !inEmpty[afp_pkg::CH_LEFT]) begin
            next_hrdata = inHead[afp_pkg::CH_LEFT];
        end else if (addrIsData[afp_pkg::CH_RIGHT] && !inEmpty[afp_pkg::CH_RIGHT]) begin
            next_hrdata = inHead[afp_pkg::CH_RIGHT];
        end else if (haddr == afp_pkg::ADDR_CTRL) begin
            next_hrdata = ctrlWord;
        end else if (haddr == afp_pkg::ADDR_OCC) begin
            next_hrdata = occWord;
        end
    end

    // read data captured at address phase; empty FIFO reads zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hrdata <= '0;
        end else if (rdAccess) begin
            hrdata <= next_hrdata;
        end
    end

    // hsize is accepted but only whole-word transfers are supported
    logic unusedSize;
    assign unusedSize = ^hsize;

endmodule

// >>> verification/afp_audio_chk.sv
`timescale 1ns/10ps
module afp_audio_chk (
    input wire logic                 core_clk,   // clock
    input wire logic                 rst,        // sync reset
    input wire logic                 hsel,       // select
    input wire logic [31:0]          haddr,      // address
    input wire logic [1:0]           htrans,     // transfer type
    input wire logic                 hwrite,     // write flag
    input wire logic [2:0]           hsize,      // size
    input wire logic [31:0]          hwdata,     // write data
    input wire logic                 hready,     // bus ready
    input wire logic                 hreadyout,  // slave ready
    input wire logic                 hresp,      // response
    input wire logic [31:0]          hrdata,     // read data
    input wire afp_pkg::afp_stereo_s captureIn,  // capture pair
    input wire afp_pkg::afp_stereo_s playOut,    // playback pair
    input wire logic                 sampleTick, // sample strobe
    input wire logic                 irq         // interrupt
);
    localparam int GAP = afp_pkg::SAMPLE_CYCLES - 1;
    logic        take;
    logic        rdCtrl;
    logic        rdOcc;
    logic        rdBad;
    logic        wrCtrl;
    logic        seen;
    logic [11:0] gap;

    // =====================================================================
    // data phase tracking
    assign take = hsel && hready && htrans == afp_pkg::HTRANS_NONSEQ;
    always_ff @(posedge core_clk) begin
        rdCtrl <= !rst && take && !hwrite && haddr == afp_pkg::ADDR_CTRL;
        rdOcc  <= !rst && take && !hwrite && haddr == afp_pkg::ADDR_OCC;
        rdBad  <= !rst && take && !hwrite && !(haddr inside {afp_pkg::ADDR_RIGHT,
                  afp_pkg::ADDR_CTRL, afp_pkg::ADDR_OCC, afp_pkg::ADDR_LEFT});
        wrCtrl <= !rst && take && hwrite && haddr == afp_pkg::ADDR_CTRL;
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            gap  <= 12'h000;
            seen <= 1'b0;
        end else if (sampleTick) begin
            gap  <= 12'h000;
            seen <= 1'b1;
        end else begin
            gap  <= gap + 12'h001;
        end
    end

    // =====================================================================
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_TICK_PERIOD: assert property (sampleTick && seen |-> gap == 12'(GAP))
        else $error("sample strobe came early");
    AST_TICK_DUE: assert property (seen && gap == 12'(GAP) |-> sampleTick)
        else $error("sample strobe missing");
    AST_TICK_PULSE: assert property (sampleTick |=> !sampleTick)
        else $error("sample strobe longer than one cycle");
    AST_PLAY_HOLD: assert property (!$past(sampleTick) |-> $stable(playOut))
        else $error("playback pair changed between samples");
    AST_CTRL_RSVD: assert property (rdCtrl |->
        hrdata[31:10] == 22'h0 && hrdata[7:4] == 4'h0)
        else $error("unused control bits read nonzero");
    AST_UNMAPPED: assert property (rdBad |-> hrdata == 32'h0)
        else $error("unmapped read returned data");
    AST_OCC_BOUND: assert property (rdOcc |->
        hrdata[7:0] <= 8'h80 && hrdata[15:8] <= 8'h80 &&
        hrdata[23:16] <= 8'h80 && hrdata[31:24] <= 8'h80) else $error("occupancy beyond depth");
    AST_IRQ_OFF: assert property (wrCtrl && hwdata[1:0] == 2'h0 |-> ##2 !irq [*3])
        else $error("interrupt stayed with enables off");
    AST_READY: assert property (hreadyout && hresp == afp_pkg::HRESP_OKAY)
        else $error("slave stalled or errored");
    cover property (rdBad);
    cover property (sampleTick && seen);
    cover property ($rose(irq));
endmodule

bind afp_audio_port afp_audio_chk u_afp_audio_chk (.core_clk(core_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .captureIn(captureIn), .playOut(playOut), .sampleTick(sampleTick), .irq(irq));

// >>> verification/afp_codec_model.sv
`timescale 1ns/10ps
module afp_codec_model (
    input  wire logic                 core_clk,   // clock
    input  wire logic                 rst,        // sync reset
    input  wire logic                 sampleTick, // sample strobe
    input  wire afp_pkg::afp_stereo_s playOut,    // played pair
    output afp_pkg::afp_stereo_s      captureIn,  // captured pair
    output afp_pkg::afp_stereo_s      heard       // last pair played
);
    logic [31:0]          idx;
    logic                 tickDly;
    afp_pkg::afp_stereo_s smp;

    // sample only valid in the strobe cycle, inverted otherwise
    assign smp.left  = 32'hCA000000 + idx;
    assign smp.right = 32'hCB000000 + idx;
    assign captureIn = sampleTick ? smp : ~smp;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            idx     <= 32'h0;
            tickDly <= 1'b0;
            heard   <= '0;
        end else begin
            idx     <= sampleTick ? idx + 32'h1 : idx;
            tickDly <= sampleTick;
            heard   <= tickDly ? playOut : heard;
        end
    end
endmodule

// >>> verification/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic                 core_clk;
    logic                 rst;
    logic                 hsel;
    logic [31:0]          haddr;
    logic [1:0]           htrans;
    logic                 hwrite;
    logic [31:0]          hwdata;
    logic                 hreadyout;
    logic                 hresp;
    logic [31:0]          hrdata;
    logic                 sampleTick;
    logic                 irq;
    logic [31:0]          rd;
    afp_pkg::afp_stereo_s captureIn;
    afp_pkg::afp_stereo_s playOut;
    afp_pkg::afp_stereo_s heard;
    int                   n_fail = 0;
    int                   compares = 0;
    int                   cycles = 0;
    int                   nTick = 0;

    afp_audio_port u_afp_audio_port (.core_clk(core_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .captureIn(captureIn), .playOut(playOut), .sampleTick(sampleTick), .irq(irq));
    afp_codec_model u_afp_codec_model (.core_clk(core_clk), .rst(rst),
        .sampleTick(sampleTick), .playOut(playOut), .captureIn(captureIn), .heard(heard));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (!rst && sampleTick === 1'b1) nTick <= nTick + 1;
        if (cycles == 8000) begin
            n_fail = n_fail + 1;
            conclude();
        end
    end

    // =====================================================================
    // helpers
    task conclude;
        if (n_fail == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask
    task xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= afp_pkg::HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task expect_reg(input logic [31:0] a, input logic [31:0] exp, input string what);
        repeat (2) @(posedge core_clk);
        xfer(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask
    task wait_tick;
        do @(posedge core_clk); while (sampleTick !== 1'b1);
        @(posedge core_clk);
    endtask

    // =====================================================================
    // scenarios
    task t_reset_state;
        expect_reg(afp_pkg::ADDR_OCC, 32'h80800000, "occupancy");
        expect_reg(afp_pkg::ADDR_CTRL, 32'h0, "control");
        expect_reg(afp_pkg::ADDR_LEFT, 32'h0, "empty left read");
        expect_reg(32'h1000304C, 32'h0, "unmapped read");
        xfer(1'b1, afp_pkg::ADDR_OCC, 32'hFFFFFFFF);
        expect_reg(afp_pkg::ADDR_OCC, 32'h80800000, "occupancy kept");
    endtask
    task t_tx_irq;
        xfer(1'b1, afp_pkg::ADDR_CTRL, 32'h2);
        expect_reg(afp_pkg::ADDR_CTRL, 32'h202, "tx pending");
        check("irq set", 32'h1, {31'h0, irq});
        for (int i = 0; i < 33; i++) begin
            xfer(1'b1, afp_pkg::ADDR_LEFT, 32'h00001000 + 32'(i));
            xfer(1'b1, afp_pkg::ADDR_RIGHT, 32'h00002000 + 32'(i));
        end
        expect_reg(afp_pkg::ADDR_CTRL, 32'h2, "tx pending cleared");
        check("irq cleared", 32'h0, {31'h0, irq});
        expect_reg(afp_pkg::ADDR_OCC, 32'h5F5F0000, "space after 33");
    endtask
    task t_fill_full;
        for (int i = 33; i < 129; i++) xfer(1'b1, afp_pkg::ADDR_LEFT, 32'h0000A000 + 32'(i));
        expect_reg(afp_pkg::ADDR_OCC, 32'h005F0000, "left full");
    endtask
    task t_flush;
        xfer(1'b1, afp_pkg::ADDR_CTRL, 32'h8);
        xfer(1'b1, afp_pkg::ADDR_LEFT, 32'h12345678);
        expect_reg(afp_pkg::ADDR_CTRL, 32'h8, "tx flush bit");
        expect_reg(afp_pkg::ADDR_OCC, 32'h80800000, "flushed");
        xfer(1'b1, afp_pkg::ADDR_CTRL, 32'h0);
    endtask
    task t_playback;
        xfer(1'b1, afp_pkg::ADDR_LEFT, 32'h11110001);
        xfer(1'b1, afp_pkg::ADDR_RIGHT, 32'h22220001);
        wait_tick;
        check("play left", 32'h11110001, playOut.left);
        check("play right", 32'h22220001, playOut.right);
        expect_reg(afp_pkg::ADDR_OCC, 32'h80800101, "after tick");
        check("codec heard", 32'h11110001, heard.left);
        xfer(1'b0, afp_pkg::ADDR_LEFT, 32'h0);
        check("capture left", 32'hCA000000 + 32'(nTick - 1), rd);
        xfer(1'b0, afp_pkg::ADDR_RIGHT, 32'h0);
        check("capture right", 32'hCB000000 + 32'(nTick - 1), rd);
        expect_reg(afp_pkg::ADDR_OCC, 32'h80800000, "drained");
    endtask
    task t_rx_flush;
        wait_tick;
        check("play held", 32'h11110001, playOut.left);
        expect_reg(afp_pkg::ADDR_OCC, 32'h80800101, "second capture");
        xfer(1'b1, afp_pkg::ADDR_CTRL, 32'h5);
        expect_reg(afp_pkg::ADDR_OCC, 32'h80800000, "rx flushed");
        expect_reg(afp_pkg::ADDR_CTRL, 32'h5, "rx below threshold");
        xfer(1'b1, afp_pkg::ADDR_CTRL, 32'h0);
    endtask

    initial begin
        rst    = 1'b1;
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset_state();
        t_tx_irq();
        t_fill_full();
        t_flush();
        t_playback();
        t_rx_flush();
        conclude();
    end
endmodule
